// ===== src/art_timer.sv
// auto-reload timer with split and capture modes, APB registers
`timescale 1ns/100ps
module art_timer
   import art_pkg::*;
#(
   parameter int SYS_DIV = SYS_DIV_DEF,
   parameter int EXT_DIV = EXT_DIV_DEF
) (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // count sources from pins
   input  wire logic        ext_osc,
   input  wire logic        cmp_out,
   // interrupt request
   output logic             irq
);
   if (SYS_DIV < 2 || SYS_DIV > 16 || EXT_DIV < 2 || EXT_DIV > 16) begin
      $error("divider out of range 2..16");
   end

   art_byte_if lo ();
   art_byte_if hi ();

   logic             ext_s;
   logic             cmp_s;
   logic             ext_d;
   logic             cmp_d;
   logic [3:0]       sys_pre;
   logic [3:0]       ext_pre;
   logic [3:0]       next_sys_pre;
   logic [3:0]       next_ext_pre;
   logic [7:0]       ctrl;
   logic [7:0]       rld_lo;
   logic [7:0]       rld_hi;
   logic [0:0]       cfg;
   logic [IRQ_W-1:0] stat;
   logic [IRQ_W-1:0] mask;
   logic [7:0]       next_ctrl;
   logic [7:0]       next_rld_lo;
   logic [7:0]       next_rld_hi;
   logic [0:0]       next_cfg;
   logic [IRQ_W-1:0] next_stat;
   logic [IRQ_W-1:0] next_mask;
   logic             next_irq;
   logic [31:0]      next_prdata;
   logic             next_pready;
   logic             next_pslverr;
   logic             ext_rise;
   logic             cmp_rise;
   logic             ext_tick;
   logic             src_tick;
   logic             run_tick;
   logic             split;
   logic             cap_en;
   logic             lo_ff;
   logic             hi_ff;
   logic             lo_wrap;
   logic             hi_wrap;
   logic             ovf16;
   logic             hi_evt;
   logic             trig;
   logic             acc;
   logic             wr_en;
   logic             rd_en;
   logic             setup;
   logic             mapped;
   art_src_t         sel;

   // pins pass two flops before any use
   art_sync u_ext_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .din     (ext_osc),
      .dout    (ext_s)
   );

   art_sync u_cmp_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .din     (cmp_out),
      .dout    (cmp_s)
   );

   art_byte u_lo (
      .pclk    (pclk),
      .presetn (presetn),
      .bus     (lo.cnt)
   );

   art_byte u_hi (
      .pclk    (pclk),
      .presetn (presetn),
      .bus     (hi.cnt)
   );

   // source selection and prescalers
   assign sel      = art_src_t'(ctrl[CB_SEL_HI:CB_SEL_LO]);
   assign split    = ctrl[CB_SPLIT];
   assign cap_en   = ctrl[CB_CAPTURE];
   assign ext_rise = ext_s & ~ext_d;
   assign cmp_rise = cmp_s & ~cmp_d;
   assign ext_tick = ext_rise && (ext_pre == 4'(EXT_DIV - 1));

   always_comb begin
      next_sys_pre = sys_pre + 4'h1;
      if (sys_pre == 4'(SYS_DIV - 1)) begin
         next_sys_pre = 4'h0;
      end
      next_ext_pre = ext_pre;
      if (ext_rise) begin
         next_ext_pre = ext_tick ? 4'h0 : ext_pre + 4'h1;
      end
      unique case (sel)
         ART_SRC_SYS:    src_tick = 1'b1;
         ART_SRC_DIV12:  src_tick = (sys_pre == 4'(SYS_DIV - 1));
         ART_SRC_EXT:    src_tick = ext_tick;
         ART_SRC_CMP:    src_tick = cmp_rise;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_d   <= 1'b0;
         cmp_d   <= 1'b0;
         sys_pre <= 4'h0;
         ext_pre <= 4'h0;
      end else begin
         ext_d   <= ext_s;
         cmp_d   <= cmp_s;
         sys_pre <= next_sys_pre;
         ext_pre <= next_ext_pre;
      end
   end

   // counting, wrap and reload
   assign run_tick = ctrl[CB_RUN] & src_tick;
   assign lo_ff    = lo.count == BYTE_MAX;
   assign hi_ff    = hi.count == BYTE_MAX;
   assign lo_wrap  = run_tick & lo_ff;
   assign hi_wrap  = run_tick & hi_ff;
   assign ovf16    = lo_wrap & hi_ff;
   assign hi_evt   = split ? hi_wrap : ovf16;
   // capture trigger: comparator edge or external osc /EXT_DIV
   assign trig     = ctrl[CB_RUN] & cap_en & ~split &
                     (cfg[CFB_CAP_CMP] ? cmp_rise : ext_tick);

   assign lo.inc   = run_tick;
   assign hi.inc   = split ? run_tick : lo_wrap;
   assign lo.rld   = split ? lo_wrap : (ovf16 & ~cap_en);
   assign hi.rld   = split ? hi_wrap : (ovf16 & ~cap_en);
   assign lo.rval  = rld_lo;
   assign hi.rval  = rld_hi;
   assign lo.wr    = wr_en && (paddr == OFF_CNT_LO);
   assign hi.wr    = wr_en && (paddr == OFF_CNT_HI);
   assign lo.wdata = pwdata[7:0];
   assign hi.wdata = pwdata[7:0];

   // apb decode; answer comes in the first access cycle
   assign setup  = psel & ~penable;
   assign acc    = psel & penable & pready;
   assign wr_en  = acc & pwrite;
   assign rd_en  = acc & ~pwrite;
   assign mapped = paddr inside {OFF_CTRL, OFF_CNT_LO, OFF_CNT_HI,
                                 OFF_RLD_LO, OFF_RLD_HI, OFF_STAT,
                                 OFF_MASK, OFF_CFG};

   always_comb begin
      next_pready  = setup;
      next_pslverr = setup & ~mapped;
      next_prdata  = prdata;
      if (setup) begin
         next_prdata = 32'h0000_0000;
         unique case (paddr)
            OFF_CTRL:   next_prdata[7:0] = ctrl;
            OFF_CNT_LO: next_prdata[7:0] = lo.count;
            OFF_CNT_HI: next_prdata[7:0] = hi.count;
            OFF_RLD_LO: next_prdata[7:0] = rld_lo;
            OFF_RLD_HI: next_prdata[7:0] = rld_hi;
            OFF_STAT:   next_prdata[IRQ_W-1:0] = stat;
            OFF_MASK:   next_prdata[IRQ_W-1:0] = mask;
            OFF_CFG:    next_prdata[0:0] = cfg;
            default:    next_prdata = 32'h0000_0000;
         endcase
      end
   end

   // register state; hardware set wins over software clear
   always_comb begin
      next_ctrl   = ctrl;
      next_rld_lo = rld_lo;
      next_rld_hi = rld_hi;
      next_cfg    = cfg;
      next_mask   = mask;
      next_stat   = stat;
      if (wr_en) begin
         unique case (paddr)
            OFF_CTRL:   next_ctrl   = pwdata[7:0];
            OFF_RLD_LO: next_rld_lo = pwdata[7:0];
            OFF_RLD_HI: next_rld_hi = pwdata[7:0];
            OFF_MASK:   next_mask   = pwdata[IRQ_W-1:0];
            OFF_CFG:    next_cfg    = pwdata[0:0];
            default:    next_ctrl   = ctrl;
         endcase
      end
      // read clears only the bits that the read returned
      if (rd_en && paddr == OFF_STAT) begin
         next_stat = stat & ~prdata[IRQ_W-1:0];
      end
      if (trig) begin
         next_rld_lo = lo.count;
         next_rld_hi = hi.count;
      end
      next_ctrl[CB_HIGH_OVF] = next_ctrl[CB_HIGH_OVF] | hi_evt | trig;
      next_ctrl[CB_LOW_OVF]  = next_ctrl[CB_LOW_OVF] | lo_wrap;
      next_stat[IB_HIGH] = next_stat[IB_HIGH] | hi_evt;
      next_stat[IB_LOW]  = next_stat[IB_LOW] | lo_wrap;
      next_stat[IB_CAPT] = next_stat[IB_CAPT] | trig;
      next_irq = (stat[IB_HIGH] & mask[IB_HIGH]) |
                 (stat[IB_LOW] & mask[IB_LOW] & mask[IB_HIGH] &
                  ctrl[CB_LOW_IRQ_EN]) |
                 (stat[IB_CAPT] & mask[IB_CAPT] & mask[IB_HIGH]);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl    <= CTRL_RST;
         rld_lo  <= BYTE_RST;
         rld_hi  <= BYTE_RST;
         cfg     <= CFG_RST;
         mask    <= IRQ_RST;
         stat    <= IRQ_RST;
         irq     <= 1'b0;
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         ctrl    <= next_ctrl;
         rld_lo  <= next_rld_lo;
         rld_hi  <= next_rld_hi;
         cfg     <= next_cfg;
         mask    <= next_mask;
         stat    <= next_stat;
         irq     <= next_irq;
         prdata  <= next_prdata;
         pready  <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // checks
   apb_answer_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      setup |=> pready && (pslverr == !$past(mapped)))
      else $error("apb answer not given in first access cycle");

   count_sixteen_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      !split && run_tick && !lo_ff && !lo.wr && !hi.wr
      |=> lo.count == $past(lo.count) + 8'h01 &&
          hi.count == $past(hi.count))
      else $error("16-bit count did not step the low byte only");

   wrap_reload_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      !split && ovf16 && !cap_en && !lo.wr && !hi.wr
      |=> {hi.count, lo.count} == $past({rld_hi, rld_lo}))
      else $error("16-bit wrap did not reload");

   high_flag_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      !split && ovf16 |=> ctrl[CB_HIGH_OVF] && stat[IB_HIGH])
      else $error("overflow flag not set on 16-bit wrap");

   overflow_irq_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      hi_evt && mask[IB_HIGH] && !(wr_en && paddr == OFF_MASK)
      |=> ##1 irq)
      else $error("overflow did not raise the interrupt");

   low_irq_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      stat[IB_LOW] && !stat[IB_HIGH] && !stat[IB_CAPT] |=>
      irq == $past(mask[IB_LOW] && mask[IB_HIGH] && ctrl[CB_LOW_IRQ_EN]))
      else $error("low wrap interrupt gating wrong");

   split_byte_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      split && lo_wrap && !hi_ff && !lo.wr && !hi.wr
      |=> lo.count == $past(rld_lo) && ctrl[CB_LOW_OVF] &&
          hi.count == $past(hi.count) + 8'h01)
      else $error("split low byte did not reload alone");

   capture_copy_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      trig |=> {rld_hi, rld_lo} == $past({hi.count, lo.count}) &&
               ctrl[CB_HIGH_OVF])
      else $error("capture did not copy the count");

   div_twelve_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      sel == ART_SRC_DIV12 && src_tick && SYS_DIV > 8
      |=> !src_tick [*8])
      else $error("divided source ticks too often");

   cmp_sync_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      sel == ART_SRC_CMP && src_tick
      |-> $past(cmp_out, 2) && !$past(cmp_out, 3))
      else $error("comparator edge not taken after two flops");
endmodule

// ===== src/art_pkg.sv
// constants, register map and types of the auto-reload timer
package art_pkg;
   // register byte offsets, one 32-bit word each
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_CNT_LO = 8'h04;
   localparam logic [7:0] OFF_CNT_HI = 8'h08;
   localparam logic [7:0] OFF_RLD_LO = 8'h0C;
   localparam logic [7:0] OFF_RLD_HI = 8'h10;
   localparam logic [7:0] OFF_STAT   = 8'h14;
   localparam logic [7:0] OFF_MASK   = 8'h18;
   localparam logic [7:0] OFF_CFG    = 8'h1C;
   // timer_control_reg fields
   localparam int CB_HIGH_OVF   = 7;
   localparam int CB_LOW_OVF    = 6;
   localparam int CB_LOW_IRQ_EN = 5;
   localparam int CB_CAPTURE    = 4;
   localparam int CB_SPLIT      = 3;
   localparam int CB_RUN        = 2;
   localparam int CB_SEL_HI     = 1;
   localparam int CB_SEL_LO     = 0;
   // config register: capture trigger source
   localparam int CFB_CAP_CMP   = 0;
   // status and mask layout
   localparam int IB_HIGH       = 0;
   localparam int IB_LOW        = 1;
   localparam int IB_CAPT       = 2;
   localparam int IRQ_W         = 3;
   // reset values and the byte count maximum
   localparam logic [7:0]       CTRL_RST = 8'h00;
   localparam logic [7:0]       BYTE_RST = 8'h00;
   localparam logic [0:0]       CFG_RST  = 1'h0;
   localparam logic [IRQ_W-1:0] IRQ_RST  = 3'h0;
   localparam logic [7:0]       BYTE_MAX = 8'hFF;
   // source dividers
   localparam int SYS_DIV_DEF = 12;
   localparam int EXT_DIV_DEF = 8;
   // count source, gray ordered
   typedef enum logic [1:0] {
      ART_SRC_SYS    = 2'h0,
      ART_SRC_DIV12  = 2'h1,
      ART_SRC_EXT    = 2'h3,
      ART_SRC_CMP    = 2'h2
   } art_src_t;
endpackage

// ===== src/art_byte_if.sv
// control and count of one 8-bit counter byte
`timescale 1ns/100ps
interface art_byte_if;
   logic       inc;
   logic       rld;
   logic       wr;
   logic [7:0] wdata;
   logic [7:0] rval;
   logic [7:0] count;
   modport ctl (output inc, output rld, output wr, output wdata,
                output rval, input count);
   modport cnt (input inc, input rld, input wr, input wdata,
                input rval, output count);
endinterface

// ===== src/art_sync.sv
// two flip-flop synchroniser for one pin level
`timescale 1ns/100ps
module art_sync (
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // level in and out
   input  wire logic din,
   output logic      dout
);
   logic meta;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta <= 1'b0;
         dout <= 1'b0;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule

// ===== src/art_byte.sv
// one counter byte: software load, reload, increment
`timescale 1ns/100ps
module art_byte
   import art_pkg::*;
(
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // control from the timer core
   art_byte_if.cnt   bus
);
   logic [7:0] count;
   logic [7:0] next_count;

   assign bus.count = count;

   // software write wins, then reload, then increment
   always_comb begin
      next_count = count;
      if (bus.wr) begin
         next_count = bus.wdata;
      end else if (bus.rld) begin
         next_count = bus.rval;
      end else if (bus.inc) begin
         next_count = count + 8'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= BYTE_RST;
      end else begin
         count <= next_count;
      end
   end

   byte_reload_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      bus.rld && !bus.wr |=> count == $past(bus.rval))
      else $error("byte did not take its reload value");

   byte_incr_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      bus.inc && !bus.rld && !bus.wr |=> count == $past(count) + 8'h01)
      else $error("byte did not advance by one");
endmodule

// ===== testbench/tb.sv
// self-checking testbench of the auto-reload timer
`timescale 1ns/100ps
module tb
   import art_pkg::*;
;
   typedef struct packed {
      logic        err;
      logic [31:0] msk;
      logic [31:0] dat;
   } art_exp_t;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        ext_osc;
   logic        cmp_out;
   logic        irq;
   logic [31:0] lfsr;
   logic [7:0]  rl;
   logic [7:0]  rh;
   art_exp_t    q[$];
   art_exp_t    e;
   int          miscompares = 0;
   int          comparisons = 0;
   int          cycles = 0;
   int          cyc;

   art_timer DUT (
      .pclk    (pclk),
      .presetn (presetn),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .paddr   (paddr),
      .pwdata  (pwdata),
      .prdata  (prdata),
      .pready  (pready),
      .pslverr (pslverr),
      .ext_osc (ext_osc),
      .cmp_out (cmp_out),
      .irq     (irq)
   );

   function automatic logic [31:0] nxt(input logic [31:0] v);
      nxt = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction

   task automatic wrap_up();
      $display("%0d comparisons, %0d miscompares", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      comparisons++;
      if (seen !== want) begin
         miscompares++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, want);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input art_exp_t x);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      q.push_back(x);
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, '{1'b0, 32'h0, 32'h0});
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m = 32'hffff_ffff);
      apb(1'b0, a, 32'h0, '{1'b0, m, d});
   endtask

   // one comparator rise per loop, then let sync and irq settle
   task automatic pulse(input int n);
      repeat (n) begin
         @(posedge pclk);
         cmp_out <= 1'b1;
         repeat (3) @(posedge pclk);
         cmp_out <= 1'b0;
         repeat (3) @(posedge pclk);
      end
      repeat (4) @(posedge pclk);
   endtask

   // 16 ticks to wrap; per is clock cycles per tick
   task automatic src_run(input logic [1:0] s, input int per);
      wr(OFF_CTRL, 32'h0);
      wr(OFF_CNT_HI, 32'h0000_00ff);
      wr(OFF_CNT_LO, 32'h0000_00f0);
      wr(OFF_CTRL, {29'h0, 1'b1, s});
      cyc = 0;
      while (irq !== 1'b1 && cyc < 1000) begin
         @(posedge pclk);
         cyc++;
         ext_osc <= cyc[1];
         cmp_out <= cyc[1];
      end
      check(32'(cyc > 15 * per - 4 && cyc < 17 * per + 6), 32'h1);
      rd(OFF_STAT, 32'h1, 32'h1);
   endtask

   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1) begin
         if (q.size() == 0) begin
            check(32'h1, 32'h0);
         end else begin
            e = q.pop_front();
            check({31'h0, pslverr}, {31'h0, e.err});
            if (!pwrite)
               check(prdata & e.msk, e.dat & e.msk);
         end
      end
   end

   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         wrap_up();
      end
   end

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   initial begin
      presetn = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0;
      ext_osc = 1'b0;
      cmp_out = 1'b0;
      lfsr    = 32'h73a6_b621;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      check({31'h0, irq}, 32'h0);
      for (int a = 0; a < 32; a += 4)
         rd(8'(a), 32'h0);
      apb(1'b0, 8'h20, 32'h0, '{1'b1, 32'hffff_ffff, 32'h0});
      apb(1'b1, 8'h02, 32'h5, '{1'b1, 32'h0, 32'h0});
      $display("test reset done");
      for (int i = 1; i < 5; i++) begin
         lfsr = nxt(lfsr);
         wr(8'(4 * i), lfsr);
         rd(8'(4 * i), {24'h0, lfsr[7:0]});
      end
      wr(OFF_MASK, 32'hffff_ffff);
      rd(OFF_MASK, 32'h7);
      wr(OFF_CFG, 32'hffff_ffff);
      rd(OFF_CFG, 32'h1);
      wr(OFF_CFG, 32'h0);
      $display("test registers done");
      lfsr = nxt(lfsr);
      rl = lfsr[7:0] & 8'hfe;
      rh = lfsr[15:8];
      wr(OFF_RLD_LO, {24'h0, rl});
      wr(OFF_RLD_HI, {24'h0, rh});
      wr(OFF_CNT_LO, 32'h0000_00ff);
      wr(OFF_CNT_HI, 32'h0000_00ff);
      wr(OFF_MASK, 32'h1);
      wr(OFF_CTRL, 32'h0000_0006);
      pulse(1);
      check({31'h0, irq}, 32'h1);
      rd(OFF_CNT_LO, {24'h0, rl});
      rd(OFF_CNT_HI, {24'h0, rh});
      rd(OFF_CTRL, 32'h0000_0086, 32'h0000_00bf);
      rd(OFF_STAT, 32'h1, 32'h5);
      repeat (3) @(posedge pclk);
      check({31'h0, irq}, 32'h0);
      $display("test 16-bit wrap done");
      wr(OFF_CTRL, 32'h0);
      wr(OFF_CNT_HI, 32'h0);
      wr(OFF_CNT_LO, 32'h0000_00ff);
      wr(OFF_MASK, 32'h3);
      wr(OFF_CTRL, 32'h0000_0026);
      pulse(1);
      check({31'h0, irq}, 32'h1);
      rd(OFF_CNT_HI, 32'h1);
      rd(OFF_STAT, 32'h2);
      wr(OFF_CTRL, 32'h0000_0006);
      wr(OFF_CNT_LO, 32'h0000_00ff);
      pulse(1);
      check({31'h0, irq}, 32'h0);
      rd(OFF_STAT, 32'h2);
      $display("test low byte irq done");
      wr(OFF_CTRL, 32'h0);
      wr(OFF_CNT_LO, 32'h0000_00ff);
      wr(OFF_CNT_HI, 32'h0000_00fe);
      wr(OFF_CTRL, 32'h0000_000e);
      pulse(2);
      rd(OFF_CNT_LO, {24'h0, rl + 8'h01});
      rd(OFF_CNT_HI, {24'h0, rh});
      rd(OFF_CTRL, 32'h0000_00ce);
      rd(OFF_STAT, 32'h3);
      $display("test split done");
      wr(OFF_CTRL, 32'h0);
      wr(OFF_CFG, 32'h1);
      wr(OFF_CTRL, 32'h0000_0014);
      pulse(1);
      rd(OFF_STAT, 32'h4, 32'h4);
      wr(OFF_CFG, 32'h0);
      // external trigger: one capture per divider period of rises
      repeat (2 * EXT_DIV_DEF - 3) begin
         @(posedge pclk);
         ext_osc <= ~ext_osc;
      end
      repeat (4) @(posedge pclk);
      rd(OFF_STAT, 32'h0, 32'h4);
      repeat (2) begin
         @(posedge pclk);
         ext_osc <= ~ext_osc;
      end
      repeat (4) @(posedge pclk);
      rd(OFF_STAT, 32'h4, 32'h4);
      wr(OFF_MASK, 32'h1);
      $display("test capture done");
      src_run(ART_SRC_SYS, 1);
      src_run(ART_SRC_DIV12, SYS_DIV_DEF);
      src_run(ART_SRC_EXT, 4 * EXT_DIV_DEF);
      src_run(ART_SRC_CMP, 4);
      $display("test sources done");
      repeat (4) @(posedge pclk);
      wrap_up();
   end
endmodule
